// ---- src/fcm_pkg.sv ----
// Package for the frame colour classify and mark block.
// Assumes a single 125 MHz clock and AXI4-Lite register access.
`default_nettype none
package fcm_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_ID_CFG = 8'h00;
   localparam logic [7:0] OFF_ID_ENTRY = 8'h04;
   localparam logic [7:0] OFF_MK_CFG = 8'h08;
   localparam logic [7:0] OFF_MK_ENTRY = 8'h0c;
   localparam logic [7:0] OFF_HDR_IN = 8'h10;
   localparam logic [7:0] OFF_RESULT = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   // ----------------------------------------
   // Entry byte layout
   // ----------------------------------------
   localparam int VAL_MSB = 7;
   localparam int VAL_LSB = 2;
   localparam int COL_MSB = 1;
   localparam int COL_LSB = 0;
   // ----------------------------------------
   // Selector codes
   // ----------------------------------------
   localparam logic [7:0] ID_SEL_V4TOS = 8'h00;
   localparam logic [7:0] ID_SEL_V6DSCP = 8'h01;
   localparam logic [7:0] ID_SEL_PCP_LO = 8'h02;
   localparam logic [7:0] ID_SEL_PCP_HI = 8'h05;
   localparam logic [7:0] ID_SEL_DEI_LO = 8'h06;
   localparam logic [7:0] ID_SEL_DEI_HI = 8'h09;
   localparam logic [7:0] MK_SEL_PCP_HI = 8'h02;
   localparam logic [7:0] MK_SEL_DEI_LO = 8'h03;
   localparam logic [7:0] MK_SEL_DEI_HI = 8'h05;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] SEL_RESET = 8'hff;
   localparam logic [31:0] RESP_OKAY = 32'h0;

   typedef enum logic [1:0] {
      FCM_GREEN = 2'b00,
      FCM_YELLOW = 2'b01,
      FCM_RED = 2'b10,
      FCM_RSVD = 2'b11
   } fcm_color_t;

   typedef struct packed {
      logic [5:0] value;
      fcm_color_t color;
   } fcm_entry_t;

   // Header fields seen on the frame under classification
   typedef struct packed {
      logic [5:0] v4Tos;
      logic [5:0] v6Dscp;
      logic [2:0] sPcp;
      logic [2:0] cPcp;
      logic [2:0] iPcp;
      logic [2:0] bPcp;
      logic sDei;
      logic cCfi;
      logic iDei;
      logic bDei;
   } fcm_hdr_t;
endpackage : fcm_pkg
`default_nettype wire

// ---- src/fcm_entry_decode.sv ----
// Decodes one colour entry byte against a selector width.
// Assumes the caller gives the count of significant value bits.
`default_nettype none
module fcm_entry_decode
   import fcm_pkg::*;
(
   input wire logic [7:0] entryByte,
   input wire logic [2:0] sigBits,
   output fcm_pkg::fcm_entry_t entry,
   output logic colorValid
);
   logic [5:0] mask;
   always_comb
   begin
      mask = 6'h3f >> (3'd6 - sigBits);
      entry.value = entryByte[VAL_MSB:VAL_LSB] & mask;
      entry.color = fcm_color_t'(entryByte[COL_MSB:COL_LSB]);
      colorValid = (entryByte[COL_MSB:COL_LSB] != FCM_RSVD);
   end
endmodule // fcm_entry_decode
`default_nettype wire

// ---- src/fcm_classify_mark.sv ----
// Colour classification and marking for one bandwidth profile.
// Assumes an AXI4-Lite master; one clock, synchronous high reset.
//
// Function
// - Entry byte: six value, two colour bits
// - Selectors 0/1 compare six ToS/DSCP bits
// - Selectors 2-5 compare three PCP bits
// - Selectors 6-9 compare one DEI bit
// - Colour codes green, yellow, red, reserved
// - Marking selector 0-5 picks output field
// - Marking value three or one bits
// - One-bit marking value may repeat
// - Write colour into selected provider tag
// - Identification selector 10-255 reserved
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module fcm_classify_mark
   import fcm_pkg::*;
#(
   parameter int NUM_ID = 4
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fcm_pkg::fcm_hdr_t frameHdr,
   input wire logic encapMode,
   output fcm_pkg::fcm_color_t frameColor,
   output logic colorHit,
   output logic [2:0] markValue,
   output logic [2:0] markField,
   output logic markEnable,
   output logic markInNewTag
);
   import fcm_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] idSel;
      logic [NUM_ID-1:0][7:0] idEntry;
      logic [NUM_ID-1:0] idUsed;
      logic [1:0] idPtr;
      logic [7:0] mkSel;
      logic [2:0][7:0] mkEntry;
      logic [2:0] mkUsed;
      fcm_hdr_t hdrSw;
      logic [7:0] awAddr;
      logic awHeld;
      logic [31:0] wData;
      logic wHeld;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      fcm_color_t color;
      logic hit;
      logic [2:0] mkVal;
      logic mkEn;
      logic ignoredSeen;
   } fcm_state_t;

   fcm_state_t st_q, st_d;

   // ----------------------------------------
   // Selector decode
   // ----------------------------------------
   function automatic logic [2:0] idWidth(input logic [7:0] sel);
      if (sel <= ID_SEL_V6DSCP)
         idWidth = 3'd6;
      else if (sel <= ID_SEL_PCP_HI)
         idWidth = 3'd3;
      else if (sel <= ID_SEL_DEI_HI)
         idWidth = 3'd1;
      else
         idWidth = 3'd0;
   endfunction

   function automatic logic [2:0] mkWidth(input logic [7:0] sel);
      if (sel <= MK_SEL_PCP_HI)
         mkWidth = 3'd3;
      else if (sel <= MK_SEL_DEI_HI)
         mkWidth = 3'd1;
      else
         mkWidth = 3'd0;
   endfunction

   // Field under test for the live frame
   function automatic logic [5:0] pickField(input logic [7:0] sel, input fcm_hdr_t h);
      case (sel)
         8'h00: pickField = h.v4Tos;
         8'h01: pickField = h.v6Dscp;
         8'h02: pickField = {3'b0, h.sPcp};
         8'h03: pickField = {3'b0, h.cPcp};
         8'h04: pickField = {3'b0, h.iPcp};
         8'h05: pickField = {3'b0, h.bPcp};
         8'h06: pickField = {5'b0, h.sDei};
         8'h07: pickField = {5'b0, h.cCfi};
         8'h08: pickField = {5'b0, h.iDei};
         8'h09: pickField = {5'b0, h.bDei};
         default: pickField = 6'h0;
      endcase
   endfunction

   // ----------------------------------------
   // Entry decoders
   // ----------------------------------------
   fcm_entry_t idDec [NUM_ID];
   logic [NUM_ID-1:0] idColOk;
   fcm_entry_t mkDec [3];
   logic [2:0] mkColOk;
   logic [2:0] idW;
   logic [2:0] mkW;

   assign idW = idWidth(st_q.idSel);
   assign mkW = mkWidth(st_q.mkSel);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_ID; gi++)
      begin : g_id
         fcm_entry_decode u_dec (
            .entryByte(st_q.idEntry[gi]),
            .sigBits(idW),
            .entry(idDec[gi]),
            .colorValid(idColOk[gi])
         );
      end
      for (gi = 0; gi < 3; gi++)
      begin : g_mk
         fcm_entry_decode u_dec (
            .entryByte(st_q.mkEntry[gi]),
            .sigBits(mkW),
            .entry(mkDec[gi]),
            .colorValid(mkColOk[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [5:0] fieldVal;
   logic [31:0] rdMux;
   logic doWrite;
   logic doRead;
   logic [7:0] wByte;
   logic [1:0] wColor;

   always_comb
   begin
      st_d = st_q;
      fieldVal = pickField(st_q.idSel, frameHdr) & (6'h3f >> (3'd6 - idW));
      doWrite = st_q.awHeld && st_q.wHeld && !st_q.bValid;
      doRead = s_axi_arvalid && !st_q.rValid;
      wByte = st_q.wData[7:0];
      wColor = wByte[COL_MSB:COL_LSB];
      rdMux = 32'h0;

      // Write address and data are taken in either order
      if (s_axi_awvalid && !st_q.awHeld)
      begin
         st_d.awHeld = 1'b1;
         st_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.wHeld)
      begin
         st_d.wHeld = 1'b1;
         st_d.wData = s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (doWrite)
      begin
         st_d.awHeld = 1'b0;
         st_d.wHeld = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = 2'b00;
         case ({st_q.awAddr[7:2], 2'b00})
            OFF_ID_CFG:
            begin
               if (idWidth(wByte) != 3'd0)
               begin
                  st_d.idSel = wByte;
                  st_d.idUsed = '0;
                  st_d.idPtr = 2'd0;
               end
               else
                  st_d.ignoredSeen = 1'b1;
            end
            OFF_ID_ENTRY:
            begin
               // Reserved colour leaves the table untouched
               if (wColor != FCM_RSVD)
               begin
                  st_d.idEntry[st_q.idPtr] = wByte;
                  st_d.idUsed[st_q.idPtr] = 1'b1;
                  st_d.idPtr = st_q.idPtr + 2'd1;
               end
               else
                  st_d.ignoredSeen = 1'b1;
            end
            OFF_MK_CFG:
            begin
               if (mkWidth(wByte) != 3'd0)
               begin
                  st_d.mkSel = wByte;
                  st_d.mkUsed = '0;
               end
               else
                  st_d.ignoredSeen = 1'b1;
            end
            OFF_MK_ENTRY:
            begin
               // Indexed by colour, so one value may serve several colours
               if (wColor != FCM_RSVD)
               begin
                  st_d.mkEntry[wColor] = wByte;
                  st_d.mkUsed[wColor] = 1'b1;
               end
               else
                  st_d.ignoredSeen = 1'b1;
            end
            OFF_HDR_IN: st_d.hdrSw = fcm_hdr_t'(st_q.wData[27:0]);
            OFF_STATUS: st_d.ignoredSeen = 1'b0;
            default: st_d.bResp = 2'b10;
         endcase
      end
      if (st_q.bValid && s_axi_bready)
         st_d.bValid = 1'b0;

      case ({s_axi_araddr[7:2], 2'b00})
         OFF_ID_CFG: rdMux = {24'h0, st_q.idSel};
         OFF_MK_CFG: rdMux = {24'h0, st_q.mkSel};
         OFF_HDR_IN: rdMux = {4'h0, st_q.hdrSw};
         OFF_RESULT: rdMux = {24'h0, st_q.mkEn, st_q.mkVal, st_q.hit, 1'b0, st_q.color};
         OFF_STATUS: rdMux = {25'h0, st_q.ignoredSeen, st_q.mkUsed, st_q.idPtr, 1'b0};
         default: rdMux = 32'h0;
      endcase
      if (doRead)
      begin
         st_d.rValid = 1'b1;
         st_d.rData = rdMux;
         st_d.rResp = (s_axi_araddr[7:2] > OFF_STATUS[7:2]) ? 2'b10 : 2'b00;
      end
      else if (st_q.rValid && s_axi_rready)
         st_d.rValid = 1'b0;

      // Classification: first matching entry wins
      st_d.hit = 1'b0;
      st_d.color = FCM_GREEN;
      for (int k = NUM_ID - 1; k >= 0; k--)
      begin
         if (st_q.idUsed[k] && idColOk[k] && idW != 3'd0 && idDec[k].value == fieldVal)
         begin
            st_d.hit = 1'b1;
            st_d.color = idDec[k].color;
         end
      end

      // Marking needs the green and yellow entries; red is optional
      st_d.mkEn = 1'b0;
      st_d.mkVal = 3'h0;
      if (mkW != 3'd0 && st_q.mkUsed[FCM_GREEN] && st_q.mkUsed[FCM_YELLOW])
      begin
         if (st_q.mkUsed[st_d.color] && mkColOk[st_d.color])
         begin
            st_d.mkEn = 1'b1;
            st_d.mkVal = mkDec[st_d.color].value[2:0];
         end
      end
   end

   // ----------------------------------------
   // Register
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_q <= '0;
         st_q.idSel <= SEL_RESET;
         st_q.mkSel <= SEL_RESET;
      end
      else
         st_q <= st_d;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = !st_q.awHeld;
   assign s_axi_wready = !st_q.wHeld;
   assign s_axi_bvalid = st_q.bValid;
   assign s_axi_bresp = st_q.bResp;
   assign s_axi_arready = !st_q.rValid;
   assign s_axi_rvalid = st_q.rValid;
   assign s_axi_rdata = st_q.rData;
   assign s_axi_rresp = st_q.rResp;
   assign frameColor = st_q.color;
   assign colorHit = st_q.hit;
   assign markValue = st_q.mkVal;
   assign markField = st_q.mkSel[2:0];
   assign markEnable = st_q.mkEn;
   // Encapsulation writes into the added tag, transport into the existing one
   assign markInNewTag = encapMode;
endmodule // fcm_classify_mark
`default_nettype wire

// ---- tb/fcm_frame_src.sv ----
// Frame datapath model: builds the header fields of one frame.
// Assumes the bench changes its inputs just after a clock edge.
`default_nettype none
module fcm_frame_src
   import fcm_pkg::*;
(
   input wire logic [7:0] fieldSel,
   input wire logic [5:0] fieldVal,
   output fcm_pkg::fcm_hdr_t frameHdr
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcm_pkg::*;
   // Unselected fields carry the inverse, so a wrong field choice misses
   always_comb
   begin
      frameHdr = {~fieldVal, ~fieldVal, {4{~fieldVal[2:0]}}, {4{~fieldVal[0]}}};
      case (fieldSel)
         8'h00: frameHdr.v4Tos = fieldVal;
         8'h01: frameHdr.v6Dscp = fieldVal;
         8'h02: frameHdr.sPcp = fieldVal[2:0];
         8'h03: frameHdr.cPcp = fieldVal[2:0];
         8'h04: frameHdr.iPcp = fieldVal[2:0];
         8'h05: frameHdr.bPcp = fieldVal[2:0];
         8'h06: frameHdr.sDei = fieldVal[0];
         8'h07: frameHdr.cCfi = fieldVal[0];
         8'h08: frameHdr.iDei = fieldVal[0];
         8'h09: frameHdr.bDei = fieldVal[0];
         default: ;
      endcase
   end
endmodule // fcm_frame_src
`default_nettype wire

// ---- tb/fcm_classify_mark_monitor.sv ----
// Checker for the classify and mark block.
// Sees only the top module's ports; bound below.
`default_nettype none
module fcm_classify_mark_monitor
   import fcm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic encapMode,
   input wire fcm_pkg::fcm_color_t frameColor,
   input wire logic colorHit,
   input wire logic [2:0] markValue,
   input wire logic [2:0] markField,
   input wire logic markEnable,
   input wire logic markInNewTag
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcm_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_tag_follows_mode: assert property (markInNewTag == encapMode)
      else $error("new tag flag differs from mode");
   a_miss_is_green: assert property (!colorHit |-> frameColor == FCM_GREEN)
      else $error("colour without hit is not green");
   a_color_not_rsvd: assert property (frameColor != FCM_RSVD)
      else $error("reserved colour driven");
   a_mark_field_range: assert property (markEnable |-> markField <= 3'd5)
      else $error("marking on reserved field");
   a_dei_one_bit: assert property (markEnable && markField >= 3'd3 |-> markValue[2:1] == 2'b00)
      else $error("one bit field marked with wide value");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_ar_held_off: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
endmodule // fcm_classify_mark_monitor
bind fcm_classify_mark fcm_classify_mark_monitor u_mon
(
   .clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .encapMode(encapMode), .frameColor(frameColor),
   .colorHit(colorHit), .markValue(markValue), .markField(markField),
   .markEnable(markEnable), .markInNewTag(markInNewTag)
);
`default_nettype wire

// ---- tb/fcm_classify_mark_tb_top.sv ----
// Bench: AXI4-Lite master tasks, frames through the source model.
// Assumes one 125 MHz clock and synchronous reset.
`default_nettype none
module fcm_classify_mark_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fcm_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00, fSel = 8'h00;
   logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0, encapMode = 0;
   logic [31:0] wData = '0, rData;
   logic [5:0] fVal = 6'h00;
   logic awReady, wReady, bValid, arReady, rValid, colorHit, markEnable, markInNewTag;
   logic [1:0] bResp, rResp;
   logic [2:0] markValue, markField;
   fcm_color_t frameColor;
   fcm_hdr_t frameHdr;
   int fails = 0;
   int cmpCount = 0;
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end
   fcm_frame_src u_src (.fieldSel(fSel), .fieldVal(fVal), .frameHdr(frameHdr));
   fcm_classify_mark u_dut
   (
      .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .frameHdr(frameHdr), .encapMode(encapMode), .frameColor(frameColor), .colorHit(colorHit),
      .markValue(markValue), .markField(markField), .markEnable(markEnable),
      .markInNewTag(markInNewTag)
   );
   task automatic end_of_test();
      if (fails == 0 && cmpCount > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded waits only: a stuck handshake ends the run
   task automatic guard(inout int n);
      n++;
      if (n > 100)
      begin
         fails++;
         end_of_test();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ra, rw, bv;
      logic [1:0] br;
      n = 0;
      @(posedge clk_sys);
      awAddr <= a;
      wData <= {24'h0, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do
      begin
         guard(n);
         @(negedge clk_sys);
         {ra, rw, bv, br} = {awReady, wReady, bValid, bResp};
         @(posedge clk_sys);
         if (ra)
            awValid <= 1'b0;
         if (rw)
            wValid <= 1'b0;
      end while (!bv);
      bReady <= 1'b0;
      chk("bresp", 32'(er), 32'(br));
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                      input logic [1:0] er);
      int n;
      logic ra, rv;
      logic [31:0] rd;
      logic [1:0] rr;
      n = 0;
      @(posedge clk_sys);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do
      begin
         guard(n);
         @(negedge clk_sys);
         {ra, rv, rd, rr} = {arReady, rValid, rData, rResp};
         @(posedge clk_sys);
         if (ra)
            arValid <= 1'b0;
      end while (!rv);
      rReady <= 1'b0;
      chk("rdata", ed, rd & m);
      chk("rresp", 32'(er), 32'(rr));
   endtask
   task automatic frm(input logic [7:0] s, input logic [5:0] v, input logic [1:0] ec,
                      input logic eh);
      @(posedge clk_sys);
      fSel <= s;
      fVal <= v;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("color", 32'(ec), 32'(frameColor));
      chk("hit", 32'(eh), 32'(colorHit));
   endtask
   task automatic mk(input logic en, input logic [2:0] v, input logic [2:0] f);
      chk("markEnable", 32'(en), 32'(markEnable));
      chk("markField", 32'(f), 32'(markField));
      if (en)
         chk("markValue", 32'(v), 32'(markValue));
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      axr(OFF_ID_CFG, '1, {24'h0, SEL_RESET}, 2'b00);
      axr(OFF_MK_CFG, '1, {24'h0, SEL_RESET}, 2'b00);
      axr(8'h1c, '1, 32'h0, 2'b10);
      axw(8'h20, 8'h00, 2'b10);
      for (int s = 0; s < 10; s++)
      begin
         axw(OFF_ID_CFG, 8'(s), 2'b00);
         axw(OFF_ID_ENTRY, {6'h3d, 2'(s % 3)}, 2'b00);
         frm(8'(s), 6'h3d, 2'(s % 3), 1'b1);
         frm(8'(s), 6'h3c, 2'b00, 1'b0);
      end
      frm(8'h09, 6'h3d, 2'b00, 1'b1);
      axr(OFF_RESULT, 32'hf, 32'h8, 2'b00);
      axw(OFF_ID_CFG, 8'h0a, 2'b00);
      axw(OFF_ID_ENTRY, {6'h3d, 2'b10}, 2'b00);
      frm(8'h00, 6'h3d, 2'b00, 1'b0);
      axw(OFF_ID_CFG, 8'h00, 2'b00);
      axw(OFF_ID_ENTRY, {6'h3d, 2'b11}, 2'b00);
      frm(8'h00, 6'h3d, 2'b00, 1'b0);
      axr(OFF_STATUS, 32'h40, 32'h40, 2'b00);
      encapMode <= 1'b1;
      axw(OFF_ID_CFG, 8'h06, 2'b00);
      axw(OFF_ID_ENTRY, {6'h01, 2'b01}, 2'b00);
      axw(OFF_ID_ENTRY, {6'h00, 2'b10}, 2'b00);
      axw(OFF_MK_CFG, 8'h03, 2'b00);
      axw(OFF_MK_ENTRY, {6'h00, 2'b00}, 2'b00);
      axw(OFF_MK_ENTRY, {6'h3f, 2'b01}, 2'b00);
      axw(OFF_MK_ENTRY, {6'h01, 2'b10}, 2'b00);
      frm(8'h06, 6'h01, 2'b01, 1'b1);
      mk(1'b1, 3'd1, 3'd3);
      chk("newTag", 32'h1, 32'(markInNewTag));
      frm(8'h06, 6'h00, 2'b10, 1'b1);
      mk(1'b1, 3'd1, 3'd3);
      // Selector write clears marks, so red is left without an entry
      axw(OFF_MK_CFG, 8'h00, 2'b00);
      axw(OFF_MK_ENTRY, {6'h3d, 2'b00}, 2'b00);
      axw(OFF_MK_ENTRY, {6'h02, 2'b01}, 2'b00);
      frm(8'h06, 6'h01, 2'b01, 1'b1);
      mk(1'b1, 3'd2, 3'd0);
      frm(8'h06, 6'h00, 2'b10, 1'b1);
      mk(1'b0, 3'd0, 3'd0);
      // Last selector before the reserved one must survive it
      axw(OFF_MK_CFG, 8'h05, 2'b00);
      frm(8'h06, 6'h01, 2'b01, 1'b1);
      mk(1'b0, 3'd0, 3'd5);
      axw(OFF_STATUS, 8'h00, 2'b00);
      axr(OFF_STATUS, 32'h40, 32'h00, 2'b00);
      axw(OFF_MK_CFG, 8'h06, 2'b00);
      frm(8'h06, 6'h00, 2'b10, 1'b1);
      mk(1'b0, 3'd0, 3'd5);
      axr(OFF_STATUS, 32'h40, 32'h40, 2'b00);
      axw(OFF_HDR_IN, 8'h2a, 2'b00);
      axr(OFF_HDR_IN, '1, 32'h2a, 2'b00);
      end_of_test();
   end
endmodule // fcm_classify_mark_tb_top
`default_nettype wire
